// *** src/rpi_indicator.sv ***
// Signal-strength PWM indicator on a pin shared with a power-up strap
`timescale 1ns/1ps
module rpi_indicator #(
	parameter int STEP_CYC = rpi_pkg::STEP_CYC,
	parameter int MS_CYC   = rpi_pkg::MS_CYC
) (
	input  wire logic       I_CLK,
	input  wire logic       I_RESET,
	input  wire logic [7:0] I_INDICATOR_HOLD_TIME,
	input  wire logic       I_PKT_VALID,
	input  wire logic [7:0] I_PKT_STRENGTH,
	input  wire logic       I_STRAP_IN,
	output logic            O_STRAP_OUT,
	output logic            O_STRAP_OE,
	output logic            O_CMD_MODE,
	output logic            O_CMD_MODE_VALID
);

	// Margin above sensitivity to steps of high time
	function automatic logic [5:0] duty_of(input logic [7:0] str);
		logic [7:0] s;
		logic [7:0] m;
		logic [7:0] d;
		s = str;
		m = 8'h00;
		d = 8'h00;
		if (s > rpi_pkg::STR_MAX) begin
			s = rpi_pkg::STR_MAX;
		end
		if (s > rpi_pkg::SENS_LEVEL) begin
			m = s - rpi_pkg::SENS_LEVEL;
			d = 8'((16'(m) * 16'(rpi_pkg::MAP_NUM)) / 16'(rpi_pkg::MAP_DEN));
			d = d + 8'(rpi_pkg::DUTY_BASE);
		end
		if (d > 8'(rpi_pkg::DUTY_MAX)) begin
			d = 8'(rpi_pkg::DUTY_MAX);
		end
		return d[5:0];
	endfunction

	// Pin is driven only in the drive state with a live hold setting
	function automatic logic drives_pin(input rpi_pkg::rpi_state_t st, input logic on);
		return (st == rpi_pkg::ST_DRIVE) && on;
	endfunction

	// Last count of each divider and of the step index
	localparam logic [15:0] STEP_LAST = 16'(STEP_CYC - 1);
	localparam logic [15:0] MS_LAST   = 16'(MS_CYC - 1);
	localparam logic [5:0]  STEP_END  = 6'(rpi_pkg::STEPS - 1);
	localparam logic [6:0]  UNIT_LAST = 7'(rpi_pkg::HOLD_UNIT_MS - 1);

	// Pin role and dividers
	rpi_pkg::rpi_state_t state_r;
	logic [15:0]         ms_cnt_r;
	logic                ms_tick;
	logic [6:0]          unit_cnt_r;
	logic                unit_tick;
	logic [15:0]         step_cnt_r;
	logic                step_tick;
	logic [5:0]          step_idx_r;
	logic                period_end;

	// Input window count, packet and hold state
	logic [7:0]          in_ms_r;
	logic [7:0]          strength_r;
	logic                seen_pkt_r;
	logic [7:0]          hold_left_r;
	logic                active_r;

	// Duty and pin drive
	logic [5:0]          duty_r;
	logic [5:0]          duty_nxt;
	logic                hold_on;
	logic                out_nxt;

	assign hold_on = (I_INDICATOR_HOLD_TIME != rpi_pkg::HOLD_OFF);

	// Millisecond divider
	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			ms_cnt_r <= 16'h0000;
		end else if (ms_cnt_r == MS_LAST) begin
			ms_cnt_r <= 16'h0000; // Wrap each millisecond
		end else begin
			ms_cnt_r <= ms_cnt_r + 16'h0001;
		end
	end
	assign ms_tick = (ms_cnt_r == MS_LAST);

	// Hold unit divider, counts milliseconds
	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			unit_cnt_r <= 7'h00;
		end else if (ms_tick) begin
			if (unit_cnt_r == UNIT_LAST) begin
				unit_cnt_r <= 7'h00;
			end else begin
				unit_cnt_r <= unit_cnt_r + 7'h01;
			end
		end
	end
	assign unit_tick = ms_tick && (unit_cnt_r == UNIT_LAST);

	// Duty step divider
	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			step_cnt_r <= 16'h0000;
		end else if (step_cnt_r == STEP_LAST) begin
			step_cnt_r <= 16'h0000; // Wrap each duty step
		end else begin
			step_cnt_r <= step_cnt_r + 16'h0001;
		end
	end
	assign step_tick = (step_cnt_r == STEP_LAST);

	// Step index within the period
	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			step_idx_r <= 6'h00;
		end else if (step_tick) begin
			if (period_end) begin
				step_idx_r <= 6'h00;
			end else begin
				step_idx_r <= step_idx_r + 6'h01;
			end
		end
	end
	assign period_end = step_tick && (step_idx_r == STEP_END);

	// Pin role sequence after power-up
	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			state_r <= rpi_pkg::ST_SAMPLE;
			in_ms_r <= 8'h00;
		end else begin
			unique case (state_r)
				rpi_pkg::ST_SAMPLE: begin
					in_ms_r <= 8'h00;
					if (hold_on) begin
						state_r <= rpi_pkg::ST_INPUT_WAIT;
					end else begin
						state_r <= rpi_pkg::ST_INPUT_ONLY;
					end
				end
				rpi_pkg::ST_INPUT_WAIT: begin
					if (!hold_on) begin
						state_r <= rpi_pkg::ST_INPUT_ONLY;
					end else if (in_ms_r >= I_INDICATOR_HOLD_TIME) begin
						state_r <= rpi_pkg::ST_DRIVE;
					end else if (ms_tick) begin
						in_ms_r <= in_ms_r + 8'h01;
					end
				end
				rpi_pkg::ST_INPUT_ONLY: begin
					if (hold_on) begin
						state_r <= rpi_pkg::ST_DRIVE;
					end
				end
				rpi_pkg::ST_DRIVE: begin
					if (!hold_on) begin
						state_r <= rpi_pkg::ST_INPUT_ONLY;
					end
				end
			endcase
		end
	end

	// Strap capture for command mode at power-up
	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			O_CMD_MODE       <= 1'b0;
			O_CMD_MODE_VALID <= 1'b0;
		end else if (state_r == rpi_pkg::ST_SAMPLE) begin
			O_CMD_MODE       <= I_STRAP_IN;
			O_CMD_MODE_VALID <= 1'b1;
		end
	end

	// Latest packet strength
	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			strength_r <= rpi_pkg::STR_MIN;
		end else if (I_PKT_VALID) begin
			strength_r <= I_PKT_STRENGTH;
		end
	end

	// First packet seen since reset
	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			seen_pkt_r <= 1'b0;
		end else if (I_PKT_VALID) begin
			seen_pkt_r <= 1'b1;
		end
	end

	// Hold timer, restarted by each packet
	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			hold_left_r <= 8'h00;
			active_r    <= 1'b0;
		end else if (I_PKT_VALID) begin
			hold_left_r <= I_INDICATOR_HOLD_TIME;
			active_r    <= hold_on;
		end else if (I_INDICATOR_HOLD_TIME == rpi_pkg::HOLD_FOREVER) begin
			active_r <= seen_pkt_r;
		end else if (!hold_on) begin
			active_r <= 1'b0;
		end else if (active_r && unit_tick) begin
			if (hold_left_r <= 8'h01) begin
				hold_left_r <= 8'h00;
				active_r    <= 1'b0;
			end else begin
				hold_left_r <= hold_left_r - 8'h01;
			end
		end
	end

	// Duty applied from the next period onward
	always_comb begin
		duty_nxt = 6'h00;
		if (active_r) begin
			duty_nxt = duty_of(strength_r);
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			duty_r <= 6'h00;
		end else if (period_end) begin
			duty_r <= duty_nxt;
		end
	end

	// High phase first, whole steps, capped at 95 percent
	always_comb begin
		out_nxt = 1'b0;
		if (drives_pin(state_r, hold_on)) begin
			out_nxt = (step_idx_r < duty_r);
		end
	end

	// Pin level register
	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			O_STRAP_OUT <= 1'b0;
		end else begin
			O_STRAP_OUT <= out_nxt;
		end
	end

	// Pin direction register, lets go on the next clock edge after hold drops to zero
	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			O_STRAP_OE <= 1'b0;
		end else begin
			O_STRAP_OE <= drives_pin(state_r, hold_on);
		end
	end

endmodule // rpi_indicator

// *** shared/rpi_pkg.sv ***
// Constants for the signal-strength indicator on the shared strap pin
// Functional notes
// - Strap pin carries a PWM whose duty encodes received level above sensitivity.
// - Duty spans zero to 95 percent; zero means at or below sensitivity.
// - Period is 8.32 ms, made of 40 steps of 0.208 ms.
// - 10 dB gives 47.5, 20 dB gives 62.5, 30 dB gives 77.5 percent.
// - Hold setting 0 to 0x7F in 100 ms units; zero disables the indicator.
// - Show last strength until hold expires without packets, then zero duty.
// - Hold setting 0xFF keeps the last strength shown forever.
// - After power-up the duty is zero until a packet arrives.
// - During power-up the pin is an input, sampled to choose command mode.
// - After sampling, with non-zero hold, pin becomes output driven low.
// - With non-zero hold, pin stays input for the hold setting in milliseconds after power-up.
// - Packet strength is captured as 0x06 to 0x36; latest capture drives duty.
package rpi_pkg;
	// Clock and timing figures
	localparam int CLK_HZ        = 50000000;
	localparam int STEP_NS       = 208000;               // One duty step, 0.208 ms
	localparam int PERIOD_NS     = 8320000;              // Whole period, 8.32 ms
	localparam int HOLD_UNIT_MS  = 100;                  // Hold setting unit
	localparam int MS_NS         = 1000000;
	localparam int CLK_NS        = 1000000000 / CLK_HZ;
	localparam int STEP_CYC      = STEP_NS / CLK_NS;     // 10400 cycles
	localparam int MS_CYC        = MS_NS / CLK_NS;       // 50000 cycles
	localparam int STEPS         = PERIOD_NS / STEP_NS;  // 40 steps
	// Duty mapping
	localparam logic [5:0] DUTY_MAX    = 6'h26;          // 38 steps, 95 percent
	localparam logic [5:0] DUTY_BASE   = 6'h0d;          // Steps added once margin is above zero
	localparam logic [7:0] STR_MIN     = 8'h06;
	localparam logic [7:0] STR_MAX     = 8'h36;
	localparam logic [7:0] SENS_LEVEL  = 8'h06;          // Strength at sensitivity
	localparam logic [7:0] MAP_NUM     = 8'h03;          // Six steps per ten dB
	localparam logic [7:0] MAP_DEN     = 8'h05;
	// Hold setting codes
	localparam logic [7:0] HOLD_OFF    = 8'h00;
	localparam logic [7:0] HOLD_MAX    = 8'h7f;
	localparam logic [7:0] HOLD_FOREVER = 8'hff;
	// Pin state machine
	typedef enum logic [1:0] {
		ST_SAMPLE,
		ST_INPUT_WAIT,
		ST_INPUT_ONLY,
		ST_DRIVE
	} rpi_state_t;
endpackage

// *** dv/rpi_indicator_checker.sv ***
// Port assertions for the strap-pin strength indicator
`timescale 1ns/1ps
module rpi_indicator_checker #(
	parameter int STEP_CYC = 8,
	parameter int MS_CYC   = 20
) (
	input wire logic       I_CLK,
	input wire logic       I_RESET,
	input wire logic [7:0] I_INDICATOR_HOLD_TIME,
	input wire logic       I_PKT_VALID,
	input wire logic [7:0] I_PKT_STRENGTH,
	input wire logic       I_STRAP_IN,
	input wire logic       O_STRAP_OUT,
	input wire logic       O_STRAP_OE,
	input wire logic       O_CMD_MODE,
	input wire logic       O_CMD_MODE_VALID
);
	int   cyc_r;
	int   hi_r;
	int   rise_r;
	logic seen_r;
	logic pkt_r;
	default clocking @(posedge I_CLK); endclocking
	default disable iff (I_RESET);
	// Time since release, high run, distance between rising edges
	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			cyc_r  <= 0;
			hi_r   <= 0;
			rise_r <= 0;
			seen_r <= 1'b0;
			pkt_r  <= 1'b0;
		end else begin
			cyc_r  <= (cyc_r < 32'h3fffffff) ? cyc_r + 1 : cyc_r;
			hi_r   <= O_STRAP_OUT ? hi_r + 1 : 0;
			rise_r <= $rose(O_STRAP_OUT) ? 1 : rise_r + 1;
			seen_r <= seen_r | $rose(O_STRAP_OUT);
			pkt_r  <= pkt_r | I_PKT_VALID;
		end
	end
	// Release of reset, then the capture edge
	sequence s_release;
		I_RESET ##1 !I_RESET;
	endsequence
	property p_strap;
		disable iff (1'b0) s_release |=> O_CMD_MODE_VALID && O_CMD_MODE == $past(I_STRAP_IN);
	endproperty
	a_strap: assert property (p_strap) else $error("strap capture wrong");
	property p_strap_keep;
		O_CMD_MODE_VALID |=> O_CMD_MODE_VALID && $stable(O_CMD_MODE);
	endproperty
	a_strap_keep: assert property (p_strap_keep) else $error("strap moved");
	property p_oe_off;
		I_INDICATOR_HOLD_TIME == 8'h00 |=> !O_STRAP_OE && !O_STRAP_OUT;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("pin driven at zero hold");
	property p_out_oe;
		O_STRAP_OUT |-> O_STRAP_OE;
	endproperty
	a_out_oe: assert property (p_out_oe) else $error("high while not driving");
	property p_in_period;
		$rose(O_STRAP_OE) |-> cyc_r + MS_CYC >= I_INDICATOR_HOLD_TIME * MS_CYC;
	endproperty
	a_in_period: assert property (p_in_period) else $error("pin driven early");
	property p_hi_steps;
		$fell(O_STRAP_OUT) |-> hi_r % STEP_CYC == 0 && hi_r <= 38 * STEP_CYC;
	endproperty
	a_hi_steps: assert property (p_hi_steps) else $error("high run bad");
	property p_period;
		$rose(O_STRAP_OUT) && seen_r |-> rise_r % (40 * STEP_CYC) == 0;
	endproperty
	a_period: assert property (p_period) else $error("rise off period");
	property p_no_pkt;
		!pkt_r |-> !O_STRAP_OUT;
	endproperty
	a_no_pkt: assert property (p_no_pkt) else $error("high before packet");
endmodule // rpi_indicator_checker

bind rpi_indicator rpi_indicator_checker #(.STEP_CYC(STEP_CYC), .MS_CYC(MS_CYC)) u_chk (
	.I_CLK, .I_RESET, .I_INDICATOR_HOLD_TIME, .I_PKT_VALID, .I_PKT_STRENGTH, .I_STRAP_IN,
	.O_STRAP_OUT, .O_STRAP_OE, .O_CMD_MODE, .O_CMD_MODE_VALID);

// *** dv/rpi_pin_model.sv ***
// Shared strap pin: external strap driver and pin level
`timescale 1ns/1ps
module rpi_pin_model (
	input  wire logic i_oe,
	input  wire logic i_out,
	input  wire logic i_strap,
	output logic      o_pin
);
	// Strap driver lets go once the module drives
	assign o_pin = i_oe ? i_out : i_strap;
endmodule // rpi_pin_model

// *** dv/testbench.sv ***
// Self-checking bench for the strap-pin strength indicator
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin \
	$display("Error %s exp %0h got %0h", nm, ex, got); errors++; end end
module testbench;
	localparam int SC = 8;
	localparam int MC = 20;
	logic        clk = 0, rst = 1, pv = 0, strap = 0, pin, out, oe, cm, cmv;
	logic [7:0]  hold = 8'h00, ps = 8'h00, s;
	logic [15:0] n;
	logic [7:0]  corner [5] = '{8'h06, 8'h10, 8'h1a, 8'h24, 8'h36};
	int          errors = 0, n_compared = 0;
	rpi_indicator #(.STEP_CYC(SC), .MS_CYC(MC)) u_dut (.I_CLK(clk), .I_RESET(rst),
		.I_INDICATOR_HOLD_TIME(hold), .I_PKT_VALID(pv), .I_PKT_STRENGTH(ps),
		.I_STRAP_IN(pin), .O_STRAP_OUT(out), .O_STRAP_OE(oe), .O_CMD_MODE(cm),
		.O_CMD_MODE_VALID(cmv));
	rpi_pin_model u_pin (.i_oe(oe), .i_out(out), .i_strap(strap), .o_pin(pin));
	// Clock, 20 ns period
	initial forever #10 clk = ~clk;
	// Expected high cycles for a strength
	function automatic logic [15:0] exp_hi(logic [7:0] v);
		int d;
		d = 13 + 3 * (int'(v) - 6) / 5;
		if (v <= 8'h06) d = 0;
		return 16'(((d > 38) ? 38 : d) * SC);
	endfunction
	task automatic do_reset(logic [7:0] h, logic st);
		@(posedge clk);
		rst <= 1'b1;
		hold <= h;
		strap <= st;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		#1 `CHK("cmd_mode", st, cm)
		`CHK("cmd_valid", 1'b1, cmv)
	endtask
	task automatic pkt(logic [7:0] v);
		@(posedge clk);
		pv <= 1'b1;
		ps <= v;
		@(posedge clk);
		pv <= 1'b0;
	endtask
	// High cycles over one whole period, after the duty settled
	task automatic meas;
		repeat (80 * SC + 4) @(posedge clk);
		n = 0;
		repeat (40 * SC) begin
			@(posedge clk);
			#1 n = n + out;
		end
	endtask
	task automatic report_and_stop;
		$display("Compared %0d, errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// Main sequence
	initial begin
		void'($urandom(51));
		do_reset(8'h00, 1'b1);
		pkt(8'h36);
		meas();
		`CHK("oe_off", 1'b0, oe)
		`CHK("hi_off", 16'h0000, n)
		do_reset(8'h03, 1'($urandom % 2));
		repeat (30) @(posedge clk);
		`CHK("oe_input", 1'b0, oe)
		repeat (100) @(posedge clk);
		`CHK("oe_drive", 1'b1, oe)
		`CHK("out_low", 1'b0, out)
		hold <= 8'hff;
		for (int i = 0; i < 10; i++) begin
			s = (i < 5) ? corner[i] : 8'(6 + $urandom % 49);
			pkt(8'h30);
			pkt(s);
			meas();
			`CHK("hi_steps", exp_hi(s), n)
		end
		repeat (5000) @(posedge clk);
		meas();
		`CHK("hi_forever", exp_hi(s), n)
		hold <= 8'h02;
		pkt(8'h24);
		meas();
		`CHK("hi_active", exp_hi(8'h24), n)
		repeat (200 * MC) @(posedge clk);
		meas();
		`CHK("hi_expired", 16'h0000, n)
		hold <= 8'h00;
		repeat (3) @(posedge clk);
		#1 `CHK("oe_release", 1'b0, oe)
		`CHK("out_release", 1'b0, out)
		report_and_stop();
	end
endmodule // testbench
